// ### asc_cal_model.sv
`timescale 1ns/1ps
module asc_cal_model #(
	parameter int DELAY = 10
) (
	input  wire logic clk,    // System clock
	input  wire logic rst,    // Synchronous reset
	input  wire logic start,  // Calibration start pulse
	input  wire logic ok,     // Result to report
	input  wire logic silent, // Never report completion
	output logic      done,   // Completion level
	output logic      pass    // Success level
);
	int   cnt;
	logic run;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt  <= 0;
			run  <= 1'b0;
			done <= 1'b0;
			pass <= 1'b0;
		end else if (start) begin
			cnt  <= 0;
			run  <= 1'b1;
			done <= 1'b0;
			pass <= ~ok;
		end else if (run && !silent) begin
			cnt  <= cnt + 1;
			// Result settles two cycles ahead of done so both synchronisers agree
			pass <= (cnt >= DELAY - 2) ? ok : ~ok;
			if (cnt == DELAY) begin
				done <= 1'b1;
				run  <= 1'b0;
			end
		end
	end
endmodule

// ### asc_chan_div.sv
`timescale 1ns/1ps
module asc_chan_div (
	input  wire logic       clk,        // System clock
	input  wire logic       rst,        // Synchronous reset
	input  wire logic       src_tick,   // Group source half-period tick
	input  wire logic       align,      // Hold converter sequence at start
	input  wire logic [5:0] ndiv,       // Channel divisor
	input  wire logic       os16,       // 16-clock conversions when high
	input  wire logic       enable,     // Channel enabled by its group
	output logic            conv_start  // One-cycle conversion start
);
	typedef struct packed {
		logic [6:0] half_cnt;
		logic [4:0] conv_cnt;
		logic       conv_start;
	} asc_div_st_t;

	asc_div_st_t s;
	asc_div_st_t next_s;
	logic [6:0]  period;
	logic [4:0]  last;

	// Divisor zero gives one source tick per channel clock, i.e. divide by one half
	assign period = (ndiv == 6'h00) ? 7'h01 : {ndiv, 1'b0};
	assign last = os16 ? 5'h0f : 5'h1f;

	always_comb begin
		next_s = s;
		next_s.conv_start = 1'b0;
		if (align || !enable) begin
			next_s.half_cnt = 7'h00;
			next_s.conv_cnt = 5'h00;
		end else if (src_tick) begin
			if (s.half_cnt + 7'h01 >= period) begin
				next_s.half_cnt = 7'h00;
				next_s.conv_start = (s.conv_cnt == 5'h00);
				next_s.conv_cnt = (s.conv_cnt == last) ? 5'h00 : s.conv_cnt + 5'h01;
			end else begin
				next_s.half_cnt = s.half_cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign conv_start = s.conv_start;

	AST_DIV_HALF: assert property (@(posedge clk) disable iff (rst)
		(enable && !align && ndiv == 6'h00 && src_tick) |=> s.half_cnt == 7'h00)
		else $error("Divisor zero did not divide by one half");
	AST_ALIGN_QUIET: assert property (@(posedge clk) disable iff (rst)
		align |=> !s.conv_start && s.conv_cnt == 5'h00)
		else $error("Conversion started while held for alignment");
endmodule

// ### asc_ctrl.sv
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_ctrl #(
	parameter int SYNC_CYC = `ASC_SYNC_MS * 1000 * `ASC_CLK_MHZ,
	parameter int CAL_CYC  = `ASC_CAL_S * 1000000 * `ASC_CLK_MHZ
) (
	input  wire logic        clk,            // System clock, 50 MHz
	input  wire logic        rst,            // Synchronous reset
	input  wire logic [7:0]  addr,           // Register byte address
	input  wire logic [31:0] wdata,          // Write data
	input  wire logic        wr,             // Write strobe
	input  wire logic        rd,             // Read strobe
	output logic      [31:0] rdata,          // Read data, cycle after rd
	input  wire logic        ext_clk_in,     // External sample clock pin
	input  wire logic        ext_sync_in,    // External sync pin
	input  wire logic        cal_done_in,    // Calibration engine done
	input  wire logic        cal_ok_in,      // Calibration engine success
	output logic             clk_out,        // Forwarded sample clock
	output logic             sync_out,       // Sync pulse to targets
	output logic      [5:0]  conv_start,     // Per-channel conversion start
	output logic      [5:0]  chan_en,        // Per-channel enable
	output logic             conv_align,     // Converter alignment hold
	output logic             cal_start,      // Calibration start pulse
	output logic             chan_ready_evt, // Channels ready event
	output logic             cal_done_evt    // Calibration completed event
);
	import asc_pkg::*;

	typedef struct packed {
		logic                   sync_req;
		logic                   cal_req;
		logic                   master;
		logic [1:0]             os16;
		logic                   ready;
		logic                   pass;
		logic [1:0][3:0]        assign_code;
		logic [5:0][5:0]        ndiv;
		logic [1:0][8:0]        nrate;
		asc_sync_t              sync_st;
		logic [17:0]            sync_cnt;
		asc_cal_t               cal_st;
		logic [27:0]            cal_cnt;
		logic [2:0]             eclk;
		logic                   ext_half;
		logic                   ext_tick;
		logic [2:0]             esync;
		logic [2:0]             cdone;
		logic [1:0]             cok;
		logic [1:0][15:0]       acc;
		logic [1:0]             gen_tick;
		logic [1:0]             gtick;
		logic [5:0]             chan_en;
		logic                   clk_out;
		logic                   gen_clk;
		logic                   sync_out;
		logic [2:0]             sync_out_cnt;
		logic                   conv_align;
		logic                   cal_start;
		logic [31:0]            rdata;
		logic                   ready_evt;
		logic                   cal_evt;
	} asc_st_t;

	asc_st_t s;
	asc_st_t next_s;

	if (SYNC_CYC < 2 || SYNC_CYC >= 2 ** 18)
		$error("SYNC_CYC out of counter range");
	if (CAL_CYC < 2 || CAL_CYC >= 2 ** 28)
		$error("CAL_CYC out of counter range");

	function automatic logic src_tick_f(input logic [3:0] code, input logic [1:0] gt,
			input logic et);
		unique case (code)
			`ASC_SRC_GEN_A: src_tick_f = gt[0];
			`ASC_SRC_GEN_B: src_tick_f = gt[1];
			`ASC_SRC_EXT:   src_tick_f = et;
			default:        src_tick_f = 1'b0;
		endcase
	endfunction

	function automatic logic src_en_f(input logic [3:0] code);
		src_en_f = (code == `ASC_SRC_GEN_A) || (code == `ASC_SRC_GEN_B)
			|| (code == `ASC_SRC_EXT);
	endfunction

	logic        wr_ctrl;
	logic        sync_go;
	logic        ext_sync_edge;
	logic [16:0] sum_a;
	logic [16:0] sum_b;

	assign wr_ctrl = wr && addr == `ASC_OFS_CTRL;
	assign ext_sync_edge = s.esync[1] && !s.esync[2] && !s.master;
	assign sync_go = (wr_ctrl && wdata[`ASC_CTRL_SYNC]) || ext_sync_edge;
	// The rate value is added to ASC_NCO_BASE to form the generator step, so 9 bits keep it in band
	assign sum_a = {1'b0, s.acc[0]} + {1'b0, `ASC_NCO_BASE + {7'h00, s.nrate[0]}};
	assign sum_b = {1'b0, s.acc[1]} + {1'b0, `ASC_NCO_BASE + {7'h00, s.nrate[1]}};

	always_comb begin
		next_s = s;
		next_s.ready_evt = 1'b0;
		next_s.cal_evt = 1'b0;
		next_s.cal_start = 1'b0;
		next_s.rdata = 32'h0000_0000;

		// Pin synchronisers; stage 0 feeds only stage 1
		next_s.eclk = {s.eclk[1:0], ext_clk_in};
		next_s.esync = {s.esync[1:0], ext_sync_in};
		next_s.cdone = {s.cdone[1:0], cal_done_in};
		next_s.cok = {s.cok[0], cal_ok_in};

		// External clock halved before use as a group source
		next_s.ext_tick = 1'b0;
		if (s.eclk[1] && !s.eclk[2]) begin
			next_s.ext_half = !s.ext_half;
			next_s.ext_tick = s.ext_half;
		end

		// Rate generators
		next_s.acc[0] = sum_a[15:0];
		next_s.acc[1] = sum_b[15:0];
		next_s.gen_tick = {sum_b[16], sum_a[16]};
		if (s.gen_tick[0])
			next_s.gen_clk = !s.gen_clk;
		for (int g = 0; g < 2; g++) begin
			next_s.gtick[g] = src_tick_f(s.assign_code[g], s.gen_tick, s.ext_tick);
			for (int c = 0; c < 3; c++)
				next_s.chan_en[g * 3 + c] = src_en_f(s.assign_code[g]);
		end

		// Initiator forwards its own generator, target repeats the input clock
		next_s.clk_out = s.master ? s.gen_clk : s.eclk[1];

		// Sync output pulse stretcher
		if (s.sync_out_cnt != 3'h0)
			next_s.sync_out_cnt = s.sync_out_cnt - 3'h1;
		next_s.sync_out = s.sync_out_cnt != 3'h0;

		// Channel synchronisation sequence
		next_s.conv_align = 1'b0;
		unique case (s.sync_st)
			SYNC_IDLE: ;
			SYNC_RESET: begin
				next_s.conv_align = 1'b1;
				next_s.sync_st = SYNC_WAIT;
				next_s.sync_cnt = 18'h00001;
			end
			SYNC_WAIT: begin
				if (s.sync_cnt == 18'(SYNC_CYC - 1)) begin
					next_s.sync_st = SYNC_IDLE;
					next_s.sync_cnt = 18'h00000;
					next_s.sync_req = 1'b0;
					if (s.cal_st == CAL_IDLE) begin
						next_s.ready = 1'b1;
						next_s.ready_evt = !s.ready;
					end
				end else begin
					next_s.sync_cnt = s.sync_cnt + 18'h00001;
				end
			end
		endcase
		// A new request wins over completion in the same cycle, except that ready_evt still pulses
		if (sync_go) begin
			next_s.sync_req = 1'b1;
			next_s.ready = 1'b0;
			next_s.sync_st = SYNC_RESET;
			next_s.sync_cnt = 18'h00000;
			if (s.master && !ext_sync_edge)
				next_s.sync_out_cnt = `ASC_SYNC_OUT_CY;
		end

		// Autocalibration; offsets stay in the converter DACs until the next run
		unique case (s.cal_st)
			CAL_IDLE: begin
				if (wr_ctrl && wdata[`ASC_CTRL_CAL]) begin
					next_s.cal_st = CAL_RUN;
					next_s.cal_req = 1'b1;
					next_s.cal_start = 1'b1;
					next_s.cal_cnt = 28'h0000000;
					next_s.pass = 1'b0;
					next_s.ready = 1'b0;
				end
			end
			CAL_RUN: begin
				if (s.cdone[1] && !s.cdone[2]) begin
					next_s.cal_st = CAL_IDLE;
					next_s.cal_req = 1'b0;
					next_s.pass = s.cok[1];
					next_s.cal_evt = 1'b1;
				end else if (s.cal_cnt == 28'(CAL_CYC - 1)) begin
					next_s.cal_st = CAL_IDLE;
					next_s.cal_req = 1'b0;
					next_s.pass = 1'b0;
					next_s.cal_evt = 1'b1;
				end else begin
					next_s.cal_cnt = s.cal_cnt + 28'h0000001;
				end
			end
		endcase

		// Register writes
		if (wr) begin
			unique case (addr)
				`ASC_OFS_CTRL: begin
					next_s.master = wdata[`ASC_CTRL_MASTER];
					next_s.os16 = {wdata[`ASC_CTRL_OS16B], wdata[`ASC_CTRL_OS16A]};
				end
				`ASC_OFS_ASSIGN: next_s.assign_code = wdata[7:0];
				`ASC_OFS_DIV01: next_s.ndiv[1:0] = {wdata[13:8], wdata[5:0]};
				`ASC_OFS_DIV23: next_s.ndiv[3:2] = {wdata[13:8], wdata[5:0]};
				`ASC_OFS_DIV45: next_s.ndiv[5:4] = {wdata[13:8], wdata[5:0]};
				`ASC_OFS_RATEA: next_s.nrate[0] = wdata[8:0];
				`ASC_OFS_RATEB: next_s.nrate[1] = wdata[8:0];
				default: ;
			endcase
		end

		// Register reads, answered in the following cycle
		if (rd) begin
			unique case (addr)
				`ASC_OFS_CTRL: begin
					next_s.rdata[`ASC_CTRL_SYNC] = s.sync_req;
					next_s.rdata[`ASC_CTRL_CAL] = s.cal_req;
					next_s.rdata[`ASC_CTRL_MASTER] = s.master;
					next_s.rdata[`ASC_CTRL_READY] = s.ready;
					next_s.rdata[`ASC_CTRL_PASS] = s.pass;
					next_s.rdata[`ASC_CTRL_OS16A] = s.os16[0];
					next_s.rdata[`ASC_CTRL_OS16B] = s.os16[1];
				end
				`ASC_OFS_ASSIGN: next_s.rdata[7:0] = s.assign_code;
				`ASC_OFS_DIV01: next_s.rdata[13:0] = {s.ndiv[1], 2'b00, s.ndiv[0]};
				`ASC_OFS_DIV23: next_s.rdata[13:0] = {s.ndiv[3], 2'b00, s.ndiv[2]};
				`ASC_OFS_DIV45: next_s.rdata[13:0] = {s.ndiv[5], 2'b00, s.ndiv[4]};
				`ASC_OFS_RATEA: next_s.rdata[8:0] = s.nrate[0];
				`ASC_OFS_RATEB: next_s.rdata[8:0] = s.nrate[1];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.assign_code <= `ASC_ASSIGN_RST;
			s.ndiv <= {6{`ASC_NDIV_RST}};
			s.nrate <= {2{`ASC_NRATE_RST}};
		end else begin
			s <= next_s;
		end
	end

	for (genvar i = 0; i < 6; i++) begin : g_chan
		asc_chan_div u_div (
			.clk        (clk),
			.rst        (rst),
			.src_tick   (s.gtick[i / 3]),
			.align      (s.conv_align),
			.ndiv       (s.ndiv[i]),
			.os16       (s.os16[i / 3]),
			.enable     (s.chan_en[i]),
			.conv_start (conv_start[i])
		);
	end

	assign rdata = s.rdata;
	assign clk_out = s.clk_out;
	assign sync_out = s.sync_out;
	assign chan_en = s.chan_en;
	assign conv_align = s.conv_align;
	assign cal_start = s.cal_start;
	assign chan_ready_evt = s.ready_evt;
	assign cal_done_evt = s.cal_evt;

	AST_RATE_WRITE: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ASC_OFS_RATEA) |=> s.nrate[0] == $past(wdata[8:0]))
		else $error("Rate value not stored");
	AST_SYNC_ALIGN: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && wdata[`ASC_CTRL_SYNC]) |=> s.sync_req ##1 conv_align)
		else $error("Sync request did not align converters");
	AST_SYNC_BOUND: assert property (@(posedge clk) disable iff (rst)
		s.sync_cnt < 18'(SYNC_CYC))
		else $error("Sync sequence overran its bound");
	AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (rst)
		(s.sync_st == SYNC_WAIT && s.sync_cnt == 18'(SYNC_CYC - 1) && !sync_go)
		|=> !s.sync_req && s.sync_st == SYNC_IDLE)
		else $error("Sync bit did not self-clear");
	AST_READY_GATE: assert property (@(posedge clk) disable iff (rst)
		s.ready |-> !s.sync_req)
		else $error("Ready flag with sync pending");
	AST_TARGET_CLK: assert property (@(posedge clk) disable iff (rst)
		(!s.master && $past(!s.master)) |-> clk_out == $past(s.eclk[1]))
		else $error("Target did not repeat external clock");
	AST_SRC_OFF: assert property (@(posedge clk) disable iff (rst)
		(s.assign_code[0] > 4'h4) [*2] |-> chan_en[2:0] == 3'b000)
		else $error("Disabled group still enabled");
	AST_CAL_END: assert property (@(posedge clk) disable iff (rst)
		$fell(s.cal_req) |-> cal_done_evt && s.cal_st == CAL_IDLE)
		else $error("Calibration end without event");
	AST_CAL_START: assert property (@(posedge clk) disable iff (rst)
		(s.cal_st == CAL_IDLE && wr_ctrl && wdata[`ASC_CTRL_CAL]) |=> cal_start && !s.pass)
		else $error("Calibration start not issued");

	COV_SYNC_DONE: cover property (@(posedge clk) disable iff (rst) $rose(chan_ready_evt));
	COV_CAL_PASS: cover property (@(posedge clk) disable iff (rst) cal_done_evt && s.pass);
	COV_EXT_SYNC: cover property (@(posedge clk) disable iff (rst) ext_sync_edge);
endmodule

// ### asc_defines.svh
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// Register offsets
`define ASC_OFS_CTRL    8'h00
`define ASC_OFS_ASSIGN  8'h14
`define ASC_OFS_DIV01   8'h18
`define ASC_OFS_DIV23   8'h1c
`define ASC_OFS_DIV45   8'h20
`define ASC_OFS_RATEA   8'h24
`define ASC_OFS_RATEB   8'h28

// Board control register bit positions
`define ASC_CTRL_SYNC   0
`define ASC_CTRL_CAL    1
`define ASC_CTRL_MASTER 2
`define ASC_CTRL_READY  3
`define ASC_CTRL_PASS   4
`define ASC_CTRL_OS16A  5
`define ASC_CTRL_OS16B  6

// Reset values
`define ASC_ASSIGN_RST  8'h10
`define ASC_NDIV_RST    6'h05
`define ASC_NRATE_RST   9'h000

// Field limits and codes
`define ASC_NRATE_W     9
`define ASC_NDIV_W      6
`define ASC_SRC_GEN_A   4'h0
`define ASC_SRC_GEN_B   4'h1
`define ASC_SRC_EXT     4'h4
`define ASC_NCO_BASE    16'h1000

// Timing
`define ASC_CLK_MHZ     50
`define ASC_SYNC_MS     4
`define ASC_CAL_S       5
`define ASC_SYNC_OUT_CY 3'h4

`endif

// ### asc_pkg.sv
package asc_pkg;
	typedef enum logic [1:0] {SYNC_IDLE, SYNC_RESET, SYNC_WAIT} asc_sync_t;
	typedef enum logic {CAL_IDLE, CAL_RUN} asc_cal_t;
endpackage

// ### testbench.sv
`timescale 1ns/1ps
`include "asc_defines.svh"
module testbench;
	localparam int SYNC_N = 20;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        ext_clk_in;
	logic        ext_sync_in;
	logic        cal_done_in;
	logic        cal_ok_in;
	logic        clk_out;
	logic        sync_out;
	logic [5:0]  conv_start;
	logic [5:0]  chan_en;
	logic        conv_align;
	logic        cal_start;
	logic        chan_ready_evt;
	logic        cal_done_evt;
	logic        ok_mode;
	logic        silent;
	int          errors;
	int          tests_run;
	asc_ctrl #(.SYNC_CYC(SYNC_N), .CAL_CYC(50)) dut (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_clk_in(ext_clk_in),
		.ext_sync_in(ext_sync_in), .cal_done_in(cal_done_in), .cal_ok_in(cal_ok_in),
		.clk_out(clk_out), .sync_out(sync_out), .conv_start(conv_start), .chan_en(chan_en),
		.conv_align(conv_align), .cal_start(cal_start), .chan_ready_evt(chan_ready_evt),
		.cal_done_evt(cal_done_evt));
	asc_cal_model model (.clk(clk), .rst(rst), .start(cal_start), .ok(ok_mode),
		.silent(silent), .done(cal_done_in), .pass(cal_ok_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic give_verdict;
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = conv_align;
			1: pick = chan_ready_evt;
			2: pick = cal_start;
			3: pick = cal_done_evt;
			default: pick = sync_out;
		endcase
	endfunction
	// Waits for the chosen output; reports cycles waited, lim when it never came
	task automatic wait_on(input int s, input int lim, output int n);
		for (n = 0; n < lim && pick(s) !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic t_reset;
		logic [31:0] d;
		chk({26'h0, chan_en}, 32'h3f);
		rd_reg(`ASC_OFS_CTRL, d);
		chk(d, 32'h0);
		rd_reg(`ASC_OFS_ASSIGN, d);
		chk(d, 32'h10);
		rd_reg(`ASC_OFS_DIV01, d);
		chk(d, 32'h505);
		rd_reg(`ASC_OFS_DIV45, d);
		chk(d, 32'h505);
		rd_reg(`ASC_OFS_RATEB, d);
		chk(d, 32'h0);
		rd_reg(8'h04, d);
		chk(d, 32'h0);
	endtask
	task automatic t_rate;
		logic [31:0] d;
		wr_reg(`ASC_OFS_RATEA, 32'hffff_ffff);
		rd_reg(`ASC_OFS_RATEA, d);
		chk(d, 32'h1ff);
		wr_reg(`ASC_OFS_RATEB, 32'h0000_0166);
		rd_reg(`ASC_OFS_RATEB, d);
		chk(d, 32'h166);
	endtask
	task automatic t_assign;
		logic [3:0] c0;
		logic [3:0] c1;
		logic [5:0] e;
		for (int i = 0; i < 16; i++) begin
			c0 = i[3:0];
			c1 = 4'hf - c0;
			e = {{3{c1 == 4'h0 || c1 == 4'h1 || c1 == 4'h4}},
				{3{c0 == 4'h0 || c0 == 4'h1 || c0 == 4'h4}}};
			wr_reg(`ASC_OFS_ASSIGN, {24'h0, c1, c0});
			repeat (3) @(posedge clk);
			#1 chk({26'h0, chan_en}, {26'h0, e});
		end
		wr_reg(`ASC_OFS_ASSIGN, 32'h10);
	endtask
	task automatic t_sync(input logic [31:0] ctl, input logic ext);
		logic [31:0] d;
		int n;
		int hi;
		if (ext) begin
			wr_reg(`ASC_OFS_CTRL, 32'h0);
			@(posedge clk);
			ext_sync_in <= 1'b1;
			repeat (4) @(posedge clk);
			ext_sync_in <= 1'b0;
			#1 wait_on(0, 10, n);
			chk(n < 10, 1'b1);
		end else begin
			// Initiator role must already stand when the sync write arrives
			if (ctl[`ASC_CTRL_MASTER])
				wr_reg(`ASC_OFS_CTRL, ctl & 32'h4);
			wr_reg(`ASC_OFS_CTRL, ctl);
			#1 wait_on(0, 5, n);
			chk(n < 5, 1'b1);
		end
		if (ctl[`ASC_CTRL_MASTER]) begin
			wait_on(4, 5, n);
			for (hi = 0; hi < 10 && sync_out === 1'b1; hi++) begin
				@(posedge clk);
				#1;
			end
			chk(hi, 4);
		end else begin
			rd_reg(`ASC_OFS_CTRL, d);
			chk(d & 32'h9, 32'h1);
		end
		wait_on(1, SYNC_N + 10, n);
		chk(n < SYNC_N + 10, 1'b1);
		rd_reg(`ASC_OFS_CTRL, d);
		chk(d & 32'h9, 32'h8);
	endtask
	task automatic t_clk_fwd;
		wr_reg(`ASC_OFS_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ext_clk_in <= ~ext_clk_in;
			repeat (6) @(posedge clk);
			#1 chk(clk_out, ext_clk_in);
		end
	endtask
	// Group 0 on the external clock toggled every cycle: one source tick per 4 cycles
	task automatic t_conv(input logic [31:0] ctl, input logic [5:0] nd, input int exp);
		int first;
		int n;
		wr_reg(`ASC_OFS_ASSIGN, 32'h14);
		wr_reg(`ASC_OFS_DIV01, {18'h0, nd, 2'b00, nd});
		wr_reg(`ASC_OFS_CTRL, ctl);
		first = -1;
		for (n = 0; n < 1200; n++) begin
			@(posedge clk);
			ext_clk_in <= ~ext_clk_in;
			#1;
			if (conv_start[0] === 1'b1) begin
				if (first >= 0)
					break;
				first = n;
			end
		end
		chk(n - first, exp);
	endtask
	task automatic t_cal(input logic ok, input logic quiet, input int lim);
		logic [31:0] d;
		int n;
		ok_mode <= ok;
		silent  <= quiet;
		wr_reg(`ASC_OFS_CTRL, 32'h2);
		#1 wait_on(2, 3, n);
		chk(n < 3, 1'b1);
		wait_on(3, lim, n);
		chk(n < lim, 1'b1);
		rd_reg(`ASC_OFS_CTRL, d);
		chk(d & 32'h12, {27'h0, ok & ~quiet, 4'h0});
		wr_reg(`ASC_OFS_ASSIGN, 32'h10);
	endtask
	initial begin
		errors      = 0;
		tests_run   = 0;
		rst         = 1'b1;
		addr        = 8'h00;
		wdata       = 32'h0;
		wr          = 1'b0;
		rd          = 1'b0;
		ext_clk_in  = 1'b0;
		ext_sync_in = 1'b0;
		ok_mode     = 1'b1;
		silent      = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 t_reset();
		t_rate();
		t_assign();
		t_sync(32'h1, 1'b0);
		t_sync(32'h5, 1'b0);
		t_sync(32'h0, 1'b1);
		t_clk_fwd();
		t_conv(32'h20, 6'h00, 64);
		t_conv(32'h00, 6'h00, 128);
		t_conv(32'h20, 6'h02, 256);
		t_cal(1'b1, 1'b0, 30);
		t_cal(1'b0, 1'b0, 30);
		t_cal(1'b1, 1'b1, 70);
		give_verdict();
	end
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
